//--- common/ddr_io_cfg.svh
// Purpose: constants for the i/o capture and tristate block
// Assumes: apb byte addresses, 32-bit data
// Notes:   definitions only
`ifndef DDR_IO_CFG_SVH
`define DDR_IO_CFG_SVH

// ==========================================
// register map
`define ADDR_CTRL      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_RDATA     8'h08
`define ADDR_INDATA    8'h0c
`define CTRL_RESET     7'h00

// ==========================================
// control field positions
`define CTRL_DDR       0
`define CTRL_LATCH     1
`define CTRL_SEL_LO    2
`define CTRL_SEL_HI    3
`define CTRL_INV       4
`define CTRL_WIDE      5
`define CTRL_WSTB      6
`define CTRL_W         7

// ==========================================
// group widths and counts
`define DQ_W           18
`define NARROW_W       16
`define WIDE_MASK      18'h3ffff
`define NARROW_MASK    18'h0ffff
`define DELAY_CELL     18'h00001
`define PRE_CNT_W      8
`define WSTB_LAST      2'h3
`define WSTB_HALF      2'h2
`define WSTB_QTR       2'h1

`endif

//--- common/ddr_io_pkg.sv
// Purpose: types for the i/o capture and tristate block
// Assumes: constants live in ddr_io_cfg.svh
// Notes:   codes written out; half_t one-hot, clk_src_t binary
package ddr_io_pkg;

   // ==========================================
   // input register clock source
   typedef enum logic [1:0]
   {
      SRC_ROUTING = 2'h0,
      SRC_EDGE_A  = 2'h1,
      SRC_EDGE_B  = 2'h2,
      SRC_STROBE  = 2'h3
   } clk_src_t;

   // ==========================================
   // ddr tristate half-cycle phase
   typedef enum logic [1:0]
   {
      PH_FIRST  = 2'b01,
      PH_SECOND = 2'b10
   } half_t;

endpackage : ddr_io_pkg

//--- src/ddr_io_capture_and_tristate.sv
// Purpose: i/o-cell tristate register, input clock select,
//          strobe read capture with preamble polarity select,
//          and 90 degree shifted write strobe
// Assumes: apb slave, zero wait; strobe_clk is the delayed strobe
// Notes:   pclk state frozen while clk_en low
//
// Behaviour
// RULE1 - register core tristate control before buffer
// RULE2 - sdr: negative input, flop or latch
// RULE3 - ddr: register both inputs on rising edge
// RULE4 - ddr: next clock latches positive value
// RULE5 - mux alternates stored values each half
// RULE6 - input clock select, optional inversion
// RULE7 - 16 bits sides, 18 bits top/bottom
// RULE8 - one cell per group holds delay
// RULE9 - delayed strobe bus spans whole group
// RULE10 - read data clocked by local strobe
// RULE11 - polarity selector for synchronizing registers
// RULE12 - polarity evaluated at every read start
// RULE13 - memory floats strobe, then drives low
// RULE14 - detect float-to-low, set polarity
// RULE15 - 90 degree write strobe across bus
// RULE16 - hold polarity until next preamble
`timescale 1ns/1ps
`include "ddr_io_cfg.svh"

module ddr_io_capture_and_tristate
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              tristate_ctrl_neg_in,
   input  wire logic              tristate_ctrl_pos_in,
   input  wire logic              tristate_latch_en,
   output logic                   tristate_out,
   input  wire logic              edge_clock_a,
   input  wire logic              edge_clock_b,
   input  wire logic [`DQ_W-1:0]  gp_data_in,
   input  wire logic              strobe_clk,
   input  wire logic              strobe_driven,
   input  wire logic              strobe_level,
   input  wire logic [`DQ_W-1:0]  dq_in,
   output logic      [`DQ_W-1:0]  io_cell_strobe_bus,
   output logic      [`DQ_W-1:0]  delay_cell_sel,
   output logic                   write_strobe_ref,
   output logic      [`DQ_W-1:0]  shifted_write_strobe,
   output logic                   read_valid,
   output logic      [`DQ_W-1:0]  read_data
);

   // ==========================================
   // functions
   function automatic logic sel_edge
   (
      input logic cur,
      input logic prev,
      input logic inv
   );
      sel_edge = inv ? (prev & ~cur) : (cur & ~prev);
   endfunction : sel_edge

   function automatic logic [`DQ_W-1:0] group_mask
   (
      input logic wide
   );
      group_mask = wide ? `WIDE_MASK : `NARROW_MASK;
   endfunction : group_mask

   // ==========================================
   // registers and apb slave
   logic [`CTRL_W-1:0]    ctrl;
   logic                  polarity;
   logic [`PRE_CNT_W-1:0] pre_cnt;
   logic [`DQ_W-1:0]      in_reg;
   logic                  drv_s2;
   logic                  wr_acc;
   logic                  rd_setup;
   logic                  hit;
   ddr_io_pkg::clk_src_t  src;

   assign wr_acc   = psel & penable & pwrite & pready;
   assign rd_setup = psel & ~penable;
   assign src      = ddr_io_pkg::clk_src_t'(ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO]);
   assign hit      = (paddr == `ADDR_CTRL) | (paddr == `ADDR_STATUS)
                   | (paddr == `ADDR_RDATA) | (paddr == `ADDR_INDATA);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= `CTRL_RESET;
      else if (clk_en && wr_acc && paddr == `ADDR_CTRL)
         ctrl <= pwdata[`CTRL_W-1:0];
   end

   // answer one cycle after setup: pready set in access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         pready  <= rd_setup;
         pslverr <= rd_setup & ~hit;
         if (rd_setup && !pwrite)
         begin
            case (paddr)
               `ADDR_CTRL:
                  prdata <= {25'h0, ctrl};
               `ADDR_STATUS:
                  prdata <= {16'h0, pre_cnt, 6'h0, drv_s2, polarity};
               `ADDR_RDATA:
                  prdata <= {14'h0, read_data};
               `ADDR_INDATA:
                  prdata <= {14'h0, in_reg};
               default:
                  prdata <= 32'h0000_0000;
            endcase
         end
         else
            prdata <= 32'h0000_0000;
      end
   end

   // ==========================================
   // tristate register block
   logic             neg_q;
   logic             pos_q;
   logic             pos_latch;
   ddr_io_pkg::half_t half;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         half <= ddr_io_pkg::PH_FIRST;
      else if (clk_en)
      begin
         case (half)
            ddr_io_pkg::PH_FIRST:
               half <= ctrl[`CTRL_DDR] ? ddr_io_pkg::PH_SECOND
                                       : ddr_io_pkg::PH_FIRST;
            ddr_io_pkg::PH_SECOND:
               half <= ddr_io_pkg::PH_FIRST;
            default:
               half <= ddr_io_pkg::PH_FIRST;
         endcase
      end
   end

   // RULE1 RULE2 capture stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         neg_q <= 1'b0;
      else if (clk_en)
      begin
         if (ctrl[`CTRL_DDR])
         begin
            // RULE3 both on rising edge
            if (half == ddr_io_pkg::PH_FIRST)
               neg_q <= tristate_ctrl_neg_in;
         end
         else if (!ctrl[`CTRL_LATCH] || tristate_latch_en)
            neg_q <= tristate_ctrl_neg_in;
      end
   end

   // RULE3 positive phase register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pos_q <= 1'b0;
      else if (clk_en && half == ddr_io_pkg::PH_FIRST)
         pos_q <= tristate_ctrl_pos_in;
   end

   // RULE4 extra latch holds second half
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pos_latch <= 1'b0;
      else if (clk_en && half == ddr_io_pkg::PH_SECOND)
         pos_latch <= pos_q;
   end

   // RULE5 half-cycle output mux
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tristate_out <= 1'b0;
      else if (clk_en)
      begin
         if (ctrl[`CTRL_DDR] && half == ddr_io_pkg::PH_FIRST)
            tristate_out <= pos_latch;
         else
            tristate_out <= neg_q;
      end
   end

   // ==========================================
   // pin synchronisers
   logic [1:0]       ea_s;
   logic [1:0]       eb_s;
   logic [1:0]       stb_s;
   logic [1:0]       lvl_s;
   logic             drv_s1;
   logic [`DQ_W-1:0] gp_s1;
   logic [`DQ_W-1:0] gp_s2;
   logic             ea_p;
   logic             eb_p;
   logic             stb_p;
   logic             drv_p;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ea_s   <= 2'h0;
         eb_s   <= 2'h0;
         stb_s  <= 2'h0;
         lvl_s  <= 2'h3;
         drv_s1 <= 1'b0;
         drv_s2 <= 1'b0;
         gp_s1  <= 18'h00000;
         gp_s2  <= 18'h00000;
      end
      else if (clk_en)
      begin
         ea_s   <= {ea_s[0], edge_clock_a};
         eb_s   <= {eb_s[0], edge_clock_b};
         stb_s  <= {stb_s[0], strobe_clk};
         lvl_s  <= {lvl_s[0], strobe_level};
         drv_s1 <= strobe_driven;
         drv_s2 <= drv_s1;
         gp_s1  <= gp_data_in;
         gp_s2  <= gp_s1;
      end
   end

   // previous synced levels for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ea_p  <= 1'b0;
         eb_p  <= 1'b0;
         stb_p <= 1'b0;
         drv_p <= 1'b0;
      end
      else if (clk_en)
      begin
         ea_p  <= ea_s[1];
         eb_p  <= eb_s[1];
         stb_p <= stb_s[1];
         drv_p <= drv_s2;
      end
   end

   // ==========================================
   // input register stage clock select
   logic take_in;

   // RULE6 source and inversion
   always_comb
   begin
      case (src)
         ddr_io_pkg::SRC_ROUTING:
            take_in = 1'b1;
         ddr_io_pkg::SRC_EDGE_A:
            take_in = sel_edge(ea_s[1], ea_p, ctrl[`CTRL_INV]);
         ddr_io_pkg::SRC_EDGE_B:
            take_in = sel_edge(eb_s[1], eb_p, ctrl[`CTRL_INV]);
         ddr_io_pkg::SRC_STROBE:
            take_in = sel_edge(stb_s[1], stb_p, ctrl[`CTRL_INV]);
         default:
            take_in = 1'b0;
      endcase
   end

   // RULE7 group width masks upper bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_reg <= 18'h00000;
      else if (clk_en && take_in)
         in_reg <= gp_s2 & group_mask(ctrl[`CTRL_WIDE]);
   end

   // ==========================================
   // strobe bus and delay cell
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         io_cell_strobe_bus <= 18'h00000;
         delay_cell_sel     <= 18'h00000;
      end
      else if (clk_en)
      begin
         // RULE9 bus reaches every cell
         io_cell_strobe_bus <= group_mask(ctrl[`CTRL_WIDE]);
         // RULE8 single delay cell
         delay_cell_sel     <= `DELAY_CELL;
      end
   end

   // ==========================================
   // strobe domain read capture
   logic [1:0]       srst;
   logic [`DQ_W-1:0] cap_word;
   logic             cap_tgl;
   logic [1:0]       ack_s;
   logic             ack_tgl;

   // reset released on strobe edges only; asserts at once
   always_ff @(posedge strobe_clk or negedge presetn)
   begin
      if (!presetn)
         srst <= 2'h0;
      else
         srst <= {srst[0], 1'b1};
   end

   always_ff @(posedge strobe_clk or negedge presetn)
   begin
      if (!presetn)
         ack_s <= 2'h0;
      else
         ack_s <= {ack_s[0], ack_tgl};
   end

   // RULE10 word taken on local strobe
   // handshake: hold word until pclk side acknowledges
   always_ff @(posedge strobe_clk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap_word <= 18'h00000;
         cap_tgl  <= 1'b0;
      end
      else if (srst[1] && ack_s[1] == cap_tgl)
      begin
         cap_word <= dq_in;
         cap_tgl  <= ~cap_tgl;
      end
   end

   // ==========================================
   // preamble detect and polarity
   logic [1:0] tg_s;
   logic       tg_p;
   logic       phase;
   logic       preamble;
   logic       pending;

   // RULE13 float then low from memory
   // RULE14 float-to-low detection
   assign preamble = drv_s2 & ~drv_p & ~lvl_s[1];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase <= 1'b0;
      else if (clk_en)
         phase <= ~phase;
   end

   // RULE12 fresh each read
   // RULE16 held until next preamble
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         polarity <= 1'b0;
         pre_cnt  <= 8'h00;
      end
      else if (clk_en && preamble)
      begin
         polarity <= ~phase;
         pre_cnt  <= pre_cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tg_s <= 2'h0;
         tg_p <= 1'b0;
      end
      else if (clk_en)
      begin
         tg_s <= {tg_s[0], cap_tgl};
         tg_p <= tg_s[1];
      end
   end

   // RULE11 synchronizing edge by polarity
   // trades up to one cycle latency for margin against strobe
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pending <= 1'b0;
      else if (clk_en)
      begin
         if (tg_s[1] != tg_p)
            pending <= 1'b1;
         else if (phase == polarity)
            pending <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         read_data  <= 18'h00000;
         read_valid <= 1'b0;
         ack_tgl    <= 1'b0;
      end
      else if (clk_en)
      begin
         read_valid <= pending & (phase == polarity);
         if (pending && phase == polarity)
         begin
            read_data <= cap_word & group_mask(ctrl[`CTRL_WIDE]);
            ack_tgl   <= tg_p;
         end
      end
   end

   // ==========================================
   // shifted write strobe
   logic [1:0] wdiv;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wdiv <= 2'h0;
      else if (clk_en)
         wdiv <= (wdiv == `WSTB_LAST) ? 2'h0 : wdiv + 2'h1;
   end

   // RULE15 quarter period late, whole bus
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         write_strobe_ref     <= 1'b0;
         shifted_write_strobe <= 18'h00000;
      end
      else if (clk_en)
      begin
         write_strobe_ref     <= ctrl[`CTRL_WSTB] & (wdiv < `WSTB_HALF);
         // copy of the reference one pclk late: a quarter of its period,
         // and no stray pulse in the cycle the strobe is switched on
         shifted_write_strobe <= {`DQ_W{write_strobe_ref}};
      end
   end

endmodule : ddr_io_capture_and_tristate

//--- sim/ddr_mem_model.sv
// Purpose: memory side of the strobe link
// Assumes: strobe stands still between frames
// Notes:   words sent are queued for the bench
`timescale 1ns/1ps
module ddr_mem_model
(
   output logic        strobe_clk,
   output logic        strobe_driven,
   output logic        strobe_level,
   output logic [17:0] dq_in
);
   logic [17:0] sent[$];
   initial
   begin
      strobe_clk    = 1'b0;
      strobe_driven = 1'b0;
      strobe_level  = 1'b1;
      dq_in         = 18'h0;
   end
   // ====================
   // link beats
   task automatic pulse(input logic [17:0] d);
      dq_in = d;
      #31.25 strobe_clk = 1'b1;
      strobe_level = strobe_clk | !strobe_driven;
      #62.5 strobe_clk = 1'b0;
      strobe_level = strobe_clk | !strobe_driven;
      #31.25;
   endtask : pulse
   // two idle edges let the link side come out of reset
   task warm;
      repeat (2) pulse(~dq_in);
   endtask : warm
   task frame_open;
      #3.3 strobe_driven = 1'b1;
      strobe_level = 1'b0;
      #125;
   endtask : frame_open
   task automatic beat(input logic [17:0] d, input int gap);
      sent.push_back(d);
      pulse(d);
      // acknowledge needs two more strobe edges before the next word is taken
      repeat (2) pulse(d);
      #(125 * gap);
   endtask : beat
   // release; data shows inverse of last word
   task frame_close;
      strobe_driven = 1'b0;
      strobe_level  = 1'b1;
      dq_in         = ~dq_in;
   endtask : frame_close
endmodule : ddr_mem_model

//--- sim/ddr_io_capture_and_tristate_sva.sv
// Purpose: port checker for the ddr io block
// Assumes: write strobe stays on once enabled
// Notes:   bound to the block below
`timescale 1ns/1ps
`include "ddr_io_cfg.svh"
module ddr_io_sva
(
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             clk_en,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic [7:0]       paddr,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic [`DQ_W-1:0] io_cell_strobe_bus,
   input wire logic [`DQ_W-1:0] delay_cell_sel,
   input wire logic             write_strobe_ref,
   input wire logic [`DQ_W-1:0] shifted_write_strobe,
   input wire logic             read_valid,
   input wire logic [`DQ_W-1:0] read_data
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ====================
   // sequences
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_ref_run;
      write_strobe_ref ##1 (!write_strobe_ref) [*2] ##1 write_strobe_ref;
   endsequence
   // ====================
   // checks
   chk_apb_ready: assert property (s_setup ##1 clk_en |-> pready)
      else $error("pready missing after setup");
   chk_ready_once: assert property (pready && clk_en |=> !pready)
      else $error("pready held too long");
   chk_err_map: assert property (s_setup ##1 clk_en |-> pslverr != ($past(paddr) inside
      {`ADDR_CTRL, `ADDR_STATUS, `ADDR_RDATA, `ADDR_INDATA}))
      else $error("pslverr wrong for address");
   chk_err_data: assert property (pslverr |-> prdata == 32'h0)
      else $error("read data not zero on error");
   chk_valid_pulse: assert property (read_valid && clk_en |=> !read_valid)
      else $error("read_valid longer than one cycle");
   chk_bus_mask: assert property (read_valid |-> (io_cell_strobe_bus == `WIDE_MASK ||
      io_cell_strobe_bus == `NARROW_MASK) && (read_data & ~io_cell_strobe_bus) == 18'h0)
      else $error("read word outside strobe group");
   chk_delay_cell: assert property (read_valid |-> delay_cell_sel == `DELAY_CELL)
      else $error("delay cell select wrong");
   chk_wstb_shift: assert property ($past(presetn) && $past(clk_en) |->
      shifted_write_strobe == {`DQ_W{$past(write_strobe_ref)}})
      else $error("shifted strobe not one cycle behind");
   chk_ref_period: assert property ($rose(write_strobe_ref) |=> s_ref_run)
      else $error("write strobe reference shape wrong");
endmodule : ddr_io_sva

bind ddr_io_capture_and_tristate ddr_io_sva ddr_io_sva_i
(
   .pclk, .presetn, .clk_en, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
   .io_cell_strobe_bus, .delay_cell_sel, .write_strobe_ref, .shifted_write_strobe,
   .read_valid, .read_data
);

//--- sim/ddr_io_capture_and_tristate_tb.sv
// Purpose: self-checking bench for the ddr io block
// Assumes: memory model drives the link pins
// Notes:   fixed seed, corner cases mixed in
`timescale 1ns/1ps
`include "ddr_io_cfg.svh"
module ddr_io_capture_and_tristate_tb;
   logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, se, b;
   logic        tristate_ctrl_neg_in, tristate_ctrl_pos_in, tristate_latch_en, tristate_out;
   logic        edge_clock_a, edge_clock_b, strobe_clk, strobe_driven, strobe_level;
   logic        write_strobe_ref, read_valid;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [17:0] gp_data_in, dq_in, io_cell_strobe_bus, delay_cell_sel, shifted_write_strobe;
   logic [17:0] read_data, mask, v1, v2, last;
   integer      seed = 32'h87e3a155;
   int          errors, n_checks, pre, c;

   ddr_io_capture_and_tristate ddr_io_capture_and_tristate_i
   (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .tristate_ctrl_neg_in, .tristate_ctrl_pos_in, .tristate_latch_en, .tristate_out,
      .edge_clock_a, .edge_clock_b, .gp_data_in, .strobe_clk, .strobe_driven, .strobe_level,
      .dq_in, .io_cell_strobe_bus, .delay_cell_sel, .write_strobe_ref, .shifted_write_strobe,
      .read_valid, .read_data
   );
   ddr_mem_model ddr_mem_model_i (.strobe_clk, .strobe_driven, .strobe_level, .dq_in);

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      #900000;
      errors++;
      close_out;
   end
   // ====================
   // helpers
   task close_out;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
      begin
         errors++;
         close_out;
      end
   endtask : apb
   function automatic logic [17:0] exp_in(input logic [1:0] s, input logic i, input logic [17:0] a, y);
      return (s != 2'h0 && i) ? a : y;
   endfunction : exp_in
   task automatic lines(input logic a, input logic y);
      edge_clock_a <= a;
      edge_clock_b <= y;
      repeat (6) @(posedge pclk);
   endtask : lines
   task automatic sdr(input logic lat);
      logic s1, o;
      tristate_ctrl_neg_in <= 1'b0;
      tristate_latch_en    <= 1'b1;
      repeat (3) @(posedge pclk);
      s1 = 1'b0;
      repeat (24)
      begin
         @(posedge pclk);
         o = s1;
         if (tristate_latch_en || !lat)
            s1 = tristate_ctrl_neg_in;
         tristate_ctrl_neg_in <= 1'($random(seed));
         tristate_latch_en    <= 1'($random(seed));
         #1;
         chk({31'h0, tristate_out}, {31'h0, o});
      end
   endtask : sdr
   task automatic ddr(input logic n, input logic p);
      logic q;
      tristate_ctrl_neg_in <= n;
      tristate_ctrl_pos_in <= p;
      repeat (6) @(posedge pclk);
      #1 q = tristate_out;
      repeat (6)
      begin
         @(posedge pclk);
         #1;
         chk({31'h0, tristate_out}, {31'h0, (n ^ p) ? ~q : n});
         q = tristate_out;
      end
   endtask : ddr
   task automatic reads(input logic w);
      int nb;
      apb(1'b1, `ADDR_CTRL, w ? 32'h60 : 32'h40);
      mask = w ? `WIDE_MASK : `NARROW_MASK;
      repeat (3)
      begin
         ddr_mem_model_i.frame_open;
         nb = 1 + {$random(seed)} % 4;
         repeat (nb)
         begin
            last = 18'($random(seed));
            ddr_mem_model_i.beat(last, {$random(seed)} % 2);
         end
         ddr_mem_model_i.frame_close;
         repeat (20) @(posedge pclk);
      end
      pre += 3;
      chk({14'h0, io_cell_strobe_bus}, {14'h0, mask});
      chk({14'h0, delay_cell_sel}, {14'h0, `DELAY_CELL});
      chk(ddr_mem_model_i.sent.size(), 32'h0);
      apb(1'b0, `ADDR_RDATA, 32'h0);
      chk(rd, {14'h0, last & mask});
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd & 32'hff02, pre << 8);
   endtask : reads
   // ====================
   // read word monitor
   always @(posedge pclk)
      if (read_valid === 1'b1 && clk_en)
         chk({14'h0, read_data}, {14'h0, ddr_mem_model_i.sent.pop_front() & mask});
   // ====================
   // main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, edge_clock_a, edge_clock_b} = '0;
      {tristate_ctrl_neg_in, tristate_ctrl_pos_in, tristate_latch_en, gp_data_in} = '0;
      clk_en = 1'b1;
      repeat (8) @(posedge pclk);
      chk({27'h0, pready, pslverr, read_valid, tristate_out, write_strobe_ref}, 32'h0);
      chk({14'h0, shifted_write_strobe}, 32'h0);
      presetn <= 1'b1;
      ddr_mem_model_i.warm;
      apb(1'b0, `ADDR_CTRL, 32'h0);
      chk(rd, {25'h0, `CTRL_RESET});
      apb(1'b0, 8'h10, 32'h0);
      chk({se, rd[30:0]}, 32'h80000000);
      apb(1'b1, `ADDR_STATUS, 32'hffffffff);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd & 32'hff00, 32'h0);
      for (int s = 0; s < 8; s++)
      begin
         apb(1'b1, `ADDR_CTRL, 32'h20 | (s << 2));
         v1 = 18'($random(seed));
         gp_data_in <= v1;
         lines(s[1:0] == 2'h1, s[1:0] == 2'h2);
         lines(1'b0, 1'b0);
         v2 = 18'($random(seed));
         gp_data_in <= v2;
         lines(s[1:0] == 2'h2, s[1:0] == 2'h1);
         lines(1'b0, 1'b0);
         lines(s[1:0] == 2'h1, s[1:0] == 2'h2);
         apb(1'b0, `ADDR_INDATA, 32'h0);
         if (s[1:0] != 2'h3)
            chk(rd, {14'h0, exp_in(s[1:0], s[2], v1, v2)});
         lines(1'b0, 1'b0);
      end
      apb(1'b1, `ADDR_CTRL, 32'h0);
      sdr(1'b0);
      @(posedge pclk);
      clk_en <= 1'b0;
      #1 b = tristate_out;
      repeat (5)
      begin
         @(posedge pclk);
         tristate_ctrl_neg_in <= ~tristate_ctrl_neg_in;
      end
      chk({31'h0, tristate_out}, {31'h0, b});
      clk_en <= 1'b1;
      apb(1'b1, `ADDR_CTRL, 32'h2);
      sdr(1'b1);
      apb(1'b1, `ADDR_CTRL, 32'h1);
      ddr(1'b1, 1'b0);
      ddr(1'b0, 1'b1);
      ddr(1'b1, 1'b1);
      reads(1'b1);
      b = write_strobe_ref;
      c = 0;
      repeat (40)
      begin
         @(posedge pclk);
         if (write_strobe_ref && !b)
            c++;
         b = write_strobe_ref;
      end
      chk(c, 32'd10);
      reads(1'b0);
      close_out;
   end
endmodule : ddr_io_capture_and_tristate_tb
